// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   import viec_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, trap = 1'b0, bad = 1'b0, svc = 1'b0, we = 1'b0;
   logic [2:0]  nmi = 3'h0;
   logic [63:0] pin = 64'h0;
   logic [4:0]  vec = 5'h00;
   logic [5:0]  idx = 6'h00;
   logic [3:0]  lag = 4'h0;
   viec_ctl_t   wd = 4'h0, rd;
   logic        ack, vld;
   logic [15:0] code, gcode;
   logic [31:0] addr, gaddr;
   logic [7:0]  insvc;
   int          gcnt, fail_count = 0, check_count = 0;

   always #25 clk = ~clk;

   viec_ctrl dut (.CORE_CLK(clk), .RST_B(rst_b), .NONMASK_REQUEST_PIN(nmi),
      .MASKABLE_REQUEST_PIN(pin), .TRAP_REQ(trap), .TRAP_VEC(vec), .BAD_OPCODE_TRAP(bad),
      .REQ_ACK(ack), .SVC_DONE(svc), .CTL_WE(we), .CTL_IDX(idx), .CTL_WDATA(wd),
      .CTL_RDATA(rd), .REQ_VALID(vld), .REQ_CODE(code), .REQ_ADDR(addr), .IN_SERVICE(insvc));

   viec_core_model core (.clk(clk), .rst_n(rst_b), .req_valid(vld), .req_code(code),
      .req_addr(addr), .lag(lag), .req_ack(ack), .got_code(gcode), .got_addr(gaddr),
      .got_cnt(gcnt));

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // Wait for the core to take one offer, then judge it
   task automatic offer(input logic [15:0] c, input logic [31:0] a);
      int c0;
      c0 = gcnt;
      for (int i = 0; i < 40 && gcnt == c0; i++) begin
         @(posedge clk);
         #1;
      end
      chk("offers", c0 + 1, gcnt);
      chk("code", c, gcode);
      chk("addr", a, gaddr);
   endtask

   task automatic none(input int n);
      int c0;
      c0 = gcnt;
      repeat (n) @(posedge clk);
      #1;
      chk("no offer", c0, gcnt);
   endtask

   task automatic ctl(input int i, input logic m, input logic [2:0] p);
      @(posedge clk) we <= 1'b1;
      idx <= i[5:0];
      wd <= '{m, p};
      @(posedge clk) we <= 1'b0;
   endtask

   task automatic pins(input logic [63:0] m);
      @(posedge clk) pin <= m;
      repeat (2) @(posedge clk);
      pin <= 64'h0;
   endtask

   task automatic done();
      @(posedge clk) svc <= 1'b1;
      @(posedge clk) svc <= 1'b0;
   endtask

   task automatic t_reset();
      offer(CODE_RESET, 32'h0);
      chk("ctl reset", 4'hF, rd);
      ctl(9, 1'b0, 3'h5);
      repeat (2) @(posedge clk);
      chk("ctl readback", 4'h5, rd);
      $display("test reset done");
   endtask

   task automatic t_mask();
      pins(64'h2);
      none(20);
      ctl(1, 1'b0, 3'h0);
      offer(16'h0090, 32'h90);
      done();
      ctl(1, 1'b1, 3'h0);
      pins(64'h2);
      none(20);
      ctl(1, 1'b0, 3'h0);
      offer(16'h0090, 32'h90);
      done();
      for (int n = 0; n < 64; n += 21) begin
         lag <= n[3:0];
         ctl(n, 1'b0, 3'h0);
         pins(64'h1 << n);
         offer(16'h0080 + 16 * n, 32'h80 + 16 * n);
         chk("in service", 8'h01, insvc);
         done();
      end
      $display("test mask done");
   endtask

   task automatic t_prio();
      ctl(3, 1'b0, 3'h2);
      ctl(10, 1'b0, 3'h1);
      pins(64'h408);
      offer(16'h0120, 32'h120);
      none(10);
      done();
      offer(16'h00B0, 32'hB0);
      done();
      ctl(4, 1'b0, 3'h1);
      ctl(2, 1'b0, 3'h1);
      pins(64'h14);
      offer(16'h00A0, 32'hA0);
      done();
      offer(16'h00C0, 32'hC0);
      done();
      $display("test prio done");
   endtask

   task automatic t_nest();
      ctl(6, 1'b0, 3'h3);
      ctl(7, 1'b0, 3'h3);
      ctl(8, 1'b0, 3'h2);
      pins(64'h40);
      offer(16'h00E0, 32'hE0);
      pins(64'h80);
      none(20);
      pins(64'h100);
      offer(16'h0100, 32'h100);
      chk("nested", 8'h0C, insvc);
      done();
      none(10);
      done();
      offer(16'h00F0, 32'hF0);
      done();
      $display("test nest done");
   endtask

   task automatic t_exc();
      nmi <= 3'h7;
      repeat (3) @(posedge clk);
      nmi <= 3'h0;
      offer(16'h0030, 32'h30);
      none(20);
      @(posedge clk) nmi <= 3'h3;
      repeat (3) @(posedge clk);
      nmi <= 3'h0;
      offer(16'h0020, 32'h20);
      none(20);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) nmi[i] <= 1'b1;
         repeat (3) @(posedge clk);
         nmi[i] <= 1'b0;
         offer(16'h10 * (i + 1), 32'h10 * (i + 1));
      end
      for (int v = 0; v < 32; v += 5) begin
         @(posedge clk) trap <= 1'b1;
         vec <= v[4:0];
         @(posedge clk) trap <= 1'b0;
         offer((v < 16 ? 16'h40 : 16'h50) | v[3:0], v < 16 ? 32'h40 : 32'h50);
      end
      ctl(11, 1'b0, 3'h0);
      @(posedge clk) pin[11] <= 1'b1;
      bad <= 1'b1;
      trap <= 1'b1;
      vec <= 5'h13;
      @(posedge clk) bad <= 1'b0;
      trap <= 1'b0;
      @(posedge clk) pin[11] <= 1'b0;
      offer(CODE_BADOP, 32'h60);
      offer(16'h0053, 32'h50);
      offer(16'h0130, 32'h130);
      done();
      $display("test exceptions done");
   endtask

   task automatic results();
      $display("checks %0d failures %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_mask();
      t_prio();
      t_nest();
      t_exc();
      results();
   end

   // Watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
endmodule // tb

// ---- viec_core_model.sv ----
`timescale 1ns/1ps
module viec_core_model
   import viec_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              req_valid,
   input  wire logic [CODE_W-1:0] req_code,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [3:0]        lag,
   output logic                   req_ack,
   output logic [CODE_W-1:0]      got_code,
   output logic [ADDR_W-1:0]      got_addr,
   output int                     got_cnt
);
   logic [3:0] wait_q;
   logic       armed_q;

   // Takes one offer per rise of valid, after lag cycles of thought
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ack  <= 1'b0;
         wait_q   <= 4'h0;
         armed_q  <= 1'b1;
         got_cnt  <= 0;
         got_code <= 16'hFFFF;
         got_addr <= 32'hFFFFFFFF;
      end else if (req_ack && req_valid) begin
         req_ack  <= 1'b0;
         armed_q  <= 1'b0;  // Wait for valid to drop before the next one
         got_code <= req_code;
         got_addr <= req_addr;
         got_cnt  <= got_cnt + 1;
      end else if (!req_valid) begin
         armed_q <= 1'b1;
         wait_q  <= 4'h0;
      end else if (armed_q && !req_ack) begin
         if (wait_q >= lag) begin
            req_ack <= 1'b1;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule // viec_core_model

// ---- viec_ctl_bank.sv ----
`timescale 1ns/1ps
module viec_ctl_bank
   import viec_pkg::*;
#(
   parameter int N = NUM_MASK
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    we,
   input  wire logic [IDX_W-1:0]        idx,
   input  wire viec_ctl_t               wdata,
   output viec_ctl_t                    rdata,
   output viec_ctl_t [N-1:0]            ctl_all
);

   // One control register per maskable source
   for (genvar g = 0; g < N; g++) begin : g_ent
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            ctl_all[g] <= '{mask: CTL_RST_MASK, prio: CTL_RST_PRIO};
         end else if (we && idx == IDX_W'(g)) begin
            ctl_all[g] <= wdata;
         end
      end
   end

   // Registered read-back of the addressed entry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '{mask: CTL_RST_MASK, prio: CTL_RST_PRIO};
      end else begin
         rdata <= ctl_all[idx];
      end
   end

endmodule // viec_ctl_bank

// ---- viec_ctrl.sv ----
// What this block does
// - Handles 67 interrupt sources in total
// - Traps and illegal opcodes start exception processing
// - Exceptions win over competing interrupts
// - Three unmaskable request sources, own inputs
// - Sixty-four maskable sources, numbered 0 to 63
// - Eight programmable levels rank maskable requests
// - Nest only for strictly higher level
// - Masked request stays pending, offered once unmasked
// - Trap vector operand selects 32 exceptions
// - Illegal opcode reports code and handler 0x60
// - Reset reports code zero, handler zero
// - Maskable n reports 0x80 plus 16n
// - Each maskable source owns a control register
// - Equal levels: lowest source number wins
// - Unmaskable request on rising pin edge
// - Maskable request on rising pin edge
// - Simultaneous unmaskables: highest kept, rest dropped
`timescale 1ns/1ps
module viec_ctrl
   import viec_pkg::*;
(
   input  wire logic                  CORE_CLK,
   input  wire logic                  RST_B,
   input  wire logic [NUM_NMI-1:0]    NONMASK_REQUEST_PIN,
   input  wire logic [NUM_MASK-1:0]   MASKABLE_REQUEST_PIN,
   input  wire logic                  TRAP_REQ,
   input  wire logic [TVEC_W-1:0]     TRAP_VEC,
   input  wire logic                  BAD_OPCODE_TRAP,
   input  wire logic                  REQ_ACK,
   input  wire logic                  SVC_DONE,
   input  wire logic                  CTL_WE,
   input  wire logic [IDX_W-1:0]      CTL_IDX,
   input  wire viec_ctl_t             CTL_WDATA,
   output viec_ctl_t                  CTL_RDATA,
   output logic                       REQ_VALID,
   output logic [CODE_W-1:0]          REQ_CODE,
   output logic [ADDR_W-1:0]          REQ_ADDR,
   output logic [NUM_LEVEL-1:0]       IN_SERVICE
);

   typedef struct packed {
      logic [NUM_NMI-1:0]   nmi_s1;
      logic [NUM_NMI-1:0]   nmi_s2;
      logic [NUM_NMI-1:0]   nmi_s3;
      logic [NUM_MASK-1:0]  int_s1;
      logic [NUM_MASK-1:0]  int_s2;
      logic [NUM_MASK-1:0]  int_s3;
      logic [NUM_NMI-1:0]   nmi_pend;
      logic [NUM_MASK-1:0]  int_pend;
      logic                 rst_pend;
      logic                 bad_pend;
      logic                 trap_pend;
      logic [TVEC_W-1:0]    trap_vec;
      logic [NUM_LEVEL-1:0] isr;
      viec_st_t             st;
      viec_kind_t           kind;
      logic [IDX_W-1:0]     sel_idx;
      logic [LVL_W-1:0]     sel_prio;
      viec_offer_t          offer;
   } viec_state_t;

   viec_state_t             s_q;
   viec_state_t             s_d;
   logic [1:0]              rst_sync_q;
   logic                    rst_n;
   viec_ctl_t [NUM_MASK-1:0] ctl_all;
   logic [NUM_NMI-1:0]      nmi_rise;
   logic [NUM_MASK-1:0]     int_rise;
   logic [LVL_W-1:0]        ceil;
   logic                    best_ok;
   logic [IDX_W-1:0]        best_idx;
   logic [LVL_W-1:0]        best_prio;

   // Reset released through two flops
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Mask and level settings per source
   viec_ctl_bank #(.N(NUM_MASK)) u_bank (
      .clk     (CORE_CLK),
      .rst_n   (rst_n),
      .we      (CTL_WE),
      .idx     (CTL_IDX),
      .wdata   (CTL_WDATA),
      .rdata   (CTL_RDATA),
      .ctl_all (ctl_all)
   );

   // Edges seen on the synchronised pins
   assign nmi_rise = s_q.nmi_s2 & ~s_q.nmi_s3;
   assign int_rise = s_q.int_s2 & ~s_q.int_s3;

   // Best eligible maskable request under the current nesting ceiling
   always_comb begin
      ceil      = LVL_LOWEST;
      best_ok   = 1'b0;
      best_idx  = '0;
      best_prio = LVL_LOWEST;
      for (int l = NUM_LEVEL - 1; l >= 0; l--) begin
         if (s_q.isr[l]) ceil = 3'(l);
      end
      for (int i = 0; i < NUM_MASK; i++) begin
         if (s_q.int_pend[i] && !ctl_all[i].mask
             && (s_q.isr == '0 || ctl_all[i].prio < ceil)
             && (!best_ok || ctl_all[i].prio < best_prio)) begin
            best_ok   = 1'b1;
            best_idx  = 6'(i);
            best_prio = ctl_all[i].prio;
         end
      end
   end

   // Next state: sync, acknowledge, selection, new events
   always_comb begin
      s_d        = s_q;
      s_d.nmi_s1 = NONMASK_REQUEST_PIN;
      s_d.nmi_s2 = s_q.nmi_s1;
      s_d.nmi_s3 = s_q.nmi_s2;
      s_d.int_s1 = MASKABLE_REQUEST_PIN;
      s_d.int_s2 = s_q.int_s1;
      s_d.int_s3 = s_q.int_s2;
      if (SVC_DONE) begin
         s_d.isr = s_q.isr & (s_q.isr - 8'h01);               // Retire innermost level
      end
      if (s_q.st == ST_OFFER && REQ_ACK) begin
         s_d.st          = ST_IDLE;
         s_d.offer.valid = 1'b0;
         unique case (s_q.kind)
            K_RST:  s_d.rst_pend = 1'b0;
            K_BAD:  s_d.bad_pend = 1'b0;
            K_TRAP: s_d.trap_pend = 1'b0;
            K_NMI:  s_d.nmi_pend[s_q.sel_idx[1:0]] = 1'b0;
            K_MASK: begin
               s_d.int_pend[s_q.sel_idx] = 1'b0;
               s_d.isr[s_q.sel_prio]     = 1'b1;
            end
         endcase
      end else if (s_q.st == ST_IDLE) begin
         // Exceptions ahead of interrupts
         if (s_q.rst_pend) begin
            s_d.kind  = K_RST;
            s_d.offer = '{1'b1, CODE_RESET, 32'h0000_0000};
         end else if (s_q.bad_pend) begin
            s_d.kind  = K_BAD;
            s_d.offer = '{1'b1, CODE_BADOP, {16'h0000, CODE_BADOP}};
         end else if (s_q.trap_pend) begin
            s_d.kind  = K_TRAP;
            s_d.offer.code = (s_q.trap_vec[4] ? CODE_TRAP_HI : CODE_TRAP_LO)
                             | {12'h000, s_q.trap_vec[3:0]};
            s_d.offer.addr = {16'h0000, (s_q.trap_vec[4] ? CODE_TRAP_HI : CODE_TRAP_LO)};
            s_d.offer.valid = 1'b1;
         end else if (s_q.nmi_pend != '0) begin
            s_d.kind    = K_NMI;
            s_d.sel_idx = s_q.nmi_pend[2] ? 6'h02 : (s_q.nmi_pend[1] ? 6'h01 : 6'h00);
            s_d.offer.code  = CODE_NMI_STEP * (16'(s_d.sel_idx) + 16'h0001);
            s_d.offer.addr  = {16'h0000, s_d.offer.code};
            s_d.offer.valid = 1'b1;
         end else if (best_ok) begin
            s_d.kind     = K_MASK;
            s_d.sel_idx  = best_idx;
            s_d.sel_prio = best_prio;
            s_d.offer.code  = CODE_MASK_BASE + {6'h00, best_idx, 4'h0};
            s_d.offer.addr  = {16'h0000, s_d.offer.code};
            s_d.offer.valid = 1'b1;
         end
         if (s_d.offer.valid) s_d.st = ST_OFFER;
      end
      // New events after clears, so a set in the clearing cycle wins
      if (nmi_rise[2]) begin
         s_d.nmi_pend[2] = 1'b1;
      end else if (nmi_rise[1]) begin
         s_d.nmi_pend[1] = 1'b1;
      end else if (nmi_rise[0]) begin
         s_d.nmi_pend[0] = 1'b1;
      end
      s_d.int_pend = s_d.int_pend | int_rise;
      if (BAD_OPCODE_TRAP) s_d.bad_pend = 1'b1;
      if (TRAP_REQ && !s_d.trap_pend) begin
         s_d.trap_pend = 1'b1;
         s_d.trap_vec  = TRAP_VEC;
      end
   end

   // State register
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s_q          <= '0;
         s_q.rst_pend <= 1'b1;
         s_q.st       <= ST_IDLE;
         s_q.kind     <= K_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign REQ_VALID  = s_q.offer.valid;
   assign REQ_CODE   = s_q.offer.code;
   assign REQ_ADDR   = s_q.offer.addr;
   assign IN_SERVICE = s_q.isr;

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!rst_n);

   logic new_offer;
   assign new_offer = s_q.st == ST_IDLE && s_d.st == ST_OFFER;

   a_hold_until_ack: assert property (REQ_VALID && !REQ_ACK |=> REQ_VALID && $stable(REQ_CODE) && $stable(REQ_ADDR)) else $error("offer changed before ack");
   a_reset_vector: assert property ($rose(rst_n) |-> ##[1:2] (REQ_VALID && REQ_CODE == CODE_RESET && REQ_ADDR == 32'h0)) else $error("no reset vector after release");
   a_bad_first: assert property (s_q.st == ST_IDLE && !s_q.rst_pend && s_q.bad_pend |=> REQ_VALID && REQ_CODE == CODE_BADOP && REQ_ADDR == 32'h60) else $error("illegal opcode not offered first");
   a_trap_code: assert property (s_q.st == ST_IDLE && !s_q.rst_pend && !s_q.bad_pend && s_q.trap_pend |=> REQ_CODE[3:0] == $past(s_q.trap_vec[3:0]) && REQ_ADDR == ($past(s_q.trap_vec[4]) ? 32'h50 : 32'h40)) else $error("wrong trap code");
   a_mask_gate: assert property (new_offer && s_d.kind == K_MASK |-> !ctl_all[s_d.sel_idx].mask && s_q.int_pend[s_d.sel_idx] && (s_q.isr == '0 || s_d.sel_prio < ceil)) else $error("masked or low level offered");
   a_mask_code: assert property (new_offer && s_d.kind == K_MASK |=> REQ_CODE == 16'h0080 + 16'(s_q.sel_idx) * 16'h0010 && REQ_ADDR == {16'h0, REQ_CODE}) else $error("wrong maskable code");
   a_nmi_code: assert property (new_offer && s_d.kind == K_NMI |=> REQ_ADDR == 32'h10 * (32'(s_q.sel_idx) + 32'h1) && s_q.sel_idx <= 6'h02) else $error("wrong nmi code");
   a_nmi_drop: assert property (nmi_rise == 3'h3 && s_q.nmi_pend == '0 |=> s_q.nmi_pend == 3'h2) else $error("lower simultaneous nmi kept");
   a_int_edge: assert property ((int_rise & ~s_q.int_pend) != '0 |=> (s_q.int_pend & $past(int_rise & ~s_q.int_pend)) == $past(int_rise & ~s_q.int_pend)) else $error("edge lost");

   c_nmi_offer: cover property (new_offer && s_d.kind == K_NMI);
   c_trap_offer: cover property (new_offer && s_d.kind == K_TRAP);
   c_nested: cover property (new_offer && s_d.kind == K_MASK && s_q.isr != '0);

endmodule // viec_ctrl

// ---- viec_pkg.sv ----
package viec_pkg;

   // Source counts and field widths
   localparam int NUM_NMI    = 3;
   localparam int NUM_MASK   = 64;
   localparam int NUM_SRC    = NUM_NMI + NUM_MASK;
   localparam int NUM_LEVEL  = 8;
   localparam int LVL_W      = 3;
   localparam int IDX_W      = 6;
   localparam int CODE_W     = 16;
   localparam int ADDR_W     = 32;
   localparam int TVEC_W     = 5;

   // Exception codes; handler address equals code except for traps
   localparam logic [CODE_W-1:0] CODE_RESET     = 16'h0000;
   localparam logic [CODE_W-1:0] CODE_NMI_STEP  = 16'h0010;
   localparam logic [CODE_W-1:0] CODE_TRAP_LO   = 16'h0040;
   localparam logic [CODE_W-1:0] CODE_TRAP_HI   = 16'h0050;
   localparam logic [CODE_W-1:0] CODE_BADOP     = 16'h0060;
   localparam logic [CODE_W-1:0] CODE_MASK_BASE = 16'h0080;

   // Reset values of a source control entry and of the level ceiling
   localparam logic             CTL_RST_MASK = 1'b1;
   localparam logic [LVL_W-1:0] CTL_RST_PRIO = 3'h7;
   localparam logic [LVL_W-1:0] LVL_LOWEST   = 3'h7;

   // Per-source control entry
   typedef struct packed {
      logic             mask;
      logic [LVL_W-1:0] prio;
   } viec_ctl_t;

   // Request handed to the core
   typedef struct packed {
      logic              valid;
      logic [CODE_W-1:0] code;
      logic [ADDR_W-1:0] addr;
   } viec_offer_t;

   // Source class of the offered request
   typedef enum logic [2:0] {
      K_RST  = 3'h0,
      K_BAD  = 3'h1,
      K_TRAP = 3'h3,
      K_NMI  = 3'h2,
      K_MASK = 3'h6
   } viec_kind_t;

   typedef enum logic {
      ST_IDLE  = 1'b0,
      ST_OFFER = 1'b1
   } viec_st_t;

endpackage
